/* File: verilog/sdiv_defs.vh */
// Constants for the serial divide unit with round-off and exact division
// What this block does
// - Round-off divide develops 44 quotient digits, one per minor cycle.
// - Non-restoring division yields exactly one quotient digit each minor cycle.
// - Round-off uses digit 44 to round magnitude into characters c1..c43.
// - Quotient sign goes in character c44 of the result word.
// - A rounded quotient of zero is always written with plus sign.
// - First execute copies dividend into the tank and recirculates it unchanged.
// - Second execute loads divisor, dividend becomes first remainder, division starts.
// - Quotient of one or more, or zero divisor, flags overflow; write all ones.
// - Third execute comes 44 or more minor cycles after second; result written.
// - Final execute passes the word read to the dispatcher as next order.
// - Exact division stores truncated 43-digit quotient and remainder, each signed.
// - Exact quotient takes true quotient sign, or plus when it is zero.
// - A zero exact remainder gets a plus sign.
// - A nonzero exact remainder takes the dividend sign.
// - Remainder goes to the address after the quotient, 1023 wrapping to 0.
// - Exact division needs 43 digit cycles, one fewer than round-off.
// - Exact overflow writes all ones for both; remainder keeps dividend sign.
// - Overflow quotient sign is a one-bit toggle over operand minus signs.
`ifndef SDIV_DEFS_VH
`define SDIV_DEFS_VH

`define SDIV_WORD_W 44
`define SDIV_MAG_W 43
`define SDIV_SIGN_BIT 43
`define SDIV_ADDR_W 10
`define SDIV_ROUND_DIGITS 6'h2C
`define SDIV_EXACT_DIGITS 6'h2B
`define SDIV_TANK_DEPTH 2
`define SDIV_TANK_AW 1
`define SDIV_TANK_QUO 1'h0
`define SDIV_TANK_REM 1'h1
`define SDIV_MODE_ROUND 1'h0
`define SDIV_MODE_EXACT 1'h1

`endif

/* File: verilog/sdiv_tank.v */
// Short word tank: small word store with registered read data
`timescale 1ns/10ps
module sdiv_tank #(
    parameter WIDTH = 44,
    parameter DEPTH = 2,
    parameter AW = 1
) (
    input wire clk,
    input wire rst,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [WIDTH-1:0] wr_data,
    input wire rd_en,
    input wire [AW-1:0] rd_addr,
    output reg [WIDTH-1:0] rd_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];

    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data <= {WIDTH{1'b0}};
        end else if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule // sdiv_tank

/* File: verilog/sdiv_unit.v */
// Serial divide unit: round-off and exact division over the word memory
`timescale 1ns/10ps
`include "sdiv_defs.vh"
module sdiv_unit #(
    parameter ADDR_W = `SDIV_ADDR_W
) (
    input wire CLK,
    input wire RST,
    input wire MINOR_TICK,
    input wire EXEC,
    input wire MODE_EXACT,
    input wire [ADDR_W-1:0] EXEC_ADDR,
    input wire [`SDIV_WORD_W-1:0] MEM_RD_DATA,
    output reg MEM_WR,
    output reg [ADDR_W-1:0] MEM_WR_ADDR,
    output wire [`SDIV_WORD_W-1:0] MEM_WR_DATA,
    output reg OVERFLOW,
    output reg ORDER_VALID,
    output reg [`SDIV_WORD_W-1:0] ORDER_DATA,
    output wire READY_RESULT,
    output wire BUSY
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_LOADED = 3'h1;
    localparam [2:0] ST_DIVIDE = 3'h2;
    localparam [2:0] ST_FIN_Q = 3'h3;
    localparam [2:0] ST_FIN_R = 3'h4;
    localparam [2:0] ST_WAIT3 = 3'h5;
    localparam [2:0] ST_WAIT4 = 3'h6;
    localparam [2:0] ST_LAST = 3'h7;

    localparam MW = `SDIV_MAG_W;
    localparam WW = `SDIV_WORD_W;

    // One non-restoring step: double, then add or subtract the divisor
    function signed [MW+1:0] nr_step;
        input signed [MW+1:0] p;
        input [MW-1:0] b;
        reg signed [MW+1:0] twice;
        reg signed [MW+1:0] bx;
        begin
            twice = {p[MW:0], 1'b0};
            bx = {2'b00, b};
            if (p[MW+1]) begin
                nr_step = twice + bx;
            end else begin
                nr_step = twice - bx;
            end
        end
    endfunction

    // Build a word, forcing a plus sign on a zero magnitude
    function [WW-1:0] signed_word;
        input [MW-1:0] mag;
        input minus;
        begin
            signed_word = {minus & (|mag), mag};
        end
    endfunction

    reg [2:0] state;
    reg mode;
    reg [MW-1:0] dividend;
    reg [MW-1:0] divisor;
    reg dividend_minus;
    reg minus_toggle;
    reg ovf;
    reg signed [MW+1:0] prem;
    reg [WW-1:0] quo;
    reg [5:0] digits;
    reg [ADDR_W-1:0] quo_addr;
    reg wr_pend;
    reg [ADDR_W-1:0] wr_addr_pend;

    reg tank_we;
    reg [`SDIV_TANK_AW-1:0] tank_wa;
    reg [WW-1:0] tank_wd;
    reg tank_re;
    reg [`SDIV_TANK_AW-1:0] tank_ra;

    wire take = EXEC & MINOR_TICK;
    wire [MW-1:0] in_mag = MEM_RD_DATA[MW-1:0];
    wire in_minus = MEM_RD_DATA[`SDIV_SIGN_BIT];
    wire [5:0] need = mode ? `SDIV_EXACT_DIGITS : `SDIV_ROUND_DIGITS;
    wire signed [MW+1:0] first_rem = {2'b00, dividend} - {2'b00, in_mag};
    wire signed [MW+1:0] first_step = nr_step(first_rem, in_mag);
    wire signed [MW+1:0] next_step = nr_step(prem, divisor);
    wire over = ~first_rem[MW+1];
    wire [MW-1:0] rounded = quo[MW:1] + {{(MW-1){1'b0}}, quo[0]};
    wire signed [MW+1:0] restored = prem + {2'b00, divisor};
    wire [MW-1:0] rem_mag = prem[MW+1] ? restored[MW-1:0] : prem[MW-1:0];

    assign READY_RESULT = (state == ST_WAIT3);
    assign BUSY = (state != ST_IDLE);

    sdiv_tank #(
        .WIDTH(WW),
        .DEPTH(`SDIV_TANK_DEPTH),
        .AW(`SDIV_TANK_AW)
    ) u_tank (
        .clk(CLK),
        .rst(RST),
        .wr_en(tank_we),
        .wr_addr(tank_wa),
        .wr_data(tank_wd),
        .rd_en(tank_re),
        .rd_addr(tank_ra),
        .rd_data(MEM_WR_DATA)
    );

    // Tank write and read steering
    always @* begin
        tank_we = 1'b0;
        tank_wa = `SDIV_TANK_QUO;
        tank_wd = {WW{1'b0}};
        tank_re = 1'b0;
        tank_ra = `SDIV_TANK_QUO;
        case (state)
            ST_IDLE: begin
                if (take) begin
                    tank_we = 1'b1;
                    tank_wd = MEM_RD_DATA;
                end
            end
            ST_LOADED: begin
                // Read back the dividend in the cycle after its copy
                tank_re = wr_pend;
            end
            ST_FIN_Q: begin
                tank_we = 1'b1;
                if (ovf) begin
                    tank_wd = {minus_toggle, {MW{1'b1}}};
                end else if (mode == `SDIV_MODE_EXACT) begin
                    tank_wd = signed_word(quo[MW-1:0], minus_toggle);
                end else begin
                    tank_wd = signed_word(rounded, minus_toggle);
                end
            end
            ST_FIN_R: begin
                tank_we = 1'b1;
                tank_wa = `SDIV_TANK_REM;
                if (ovf) begin
                    tank_wd = {dividend_minus, {MW{1'b1}}};
                end else begin
                    tank_wd = signed_word(rem_mag, dividend_minus);
                end
            end
            ST_WAIT3: begin
                tank_re = take;
            end
            ST_WAIT4: begin
                tank_re = take;
                tank_ra = `SDIV_TANK_REM;
            end
            default: begin
                tank_re = 1'b0;
            end
        endcase
    end

    // Order sequence and serial digit generation
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            state <= ST_IDLE;
            mode <= `SDIV_MODE_ROUND;
            dividend <= {MW{1'b0}};
            divisor <= {MW{1'b0}};
            dividend_minus <= 1'b0;
            minus_toggle <= 1'b0;
            ovf <= 1'b0;
            prem <= {(MW+2){1'b0}};
            quo <= {WW{1'b0}};
            digits <= 6'h00;
            quo_addr <= {ADDR_W{1'b0}};
            wr_pend <= 1'b0;
            wr_addr_pend <= {ADDR_W{1'b0}};
            OVERFLOW <= 1'b0;
            ORDER_VALID <= 1'b0;
            ORDER_DATA <= {WW{1'b0}};
        end else begin
            wr_pend <= 1'b0;
            OVERFLOW <= 1'b0;
            ORDER_VALID <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (take) begin
                        mode <= MODE_EXACT;
                        dividend <= in_mag;
                        dividend_minus <= in_minus;
                        minus_toggle <= in_minus;
                        wr_pend <= 1'b1;
                        wr_addr_pend <= EXEC_ADDR;
                        state <= ST_LOADED;
                    end
                end
                ST_LOADED: begin
                    if (take) begin
                        divisor <= in_mag;
                        minus_toggle <= minus_toggle ^ in_minus;
                        if (over) begin
                            ovf <= 1'b1;
                            OVERFLOW <= 1'b1;
                            state <= ST_FIN_Q;
                        end else begin
                            ovf <= 1'b0;
                            prem <= first_step;
                            quo <= {{(WW-1){1'b0}}, ~first_step[MW+1]};
                            digits <= 6'h01;
                            state <= ST_DIVIDE;
                        end
                    end
                end
                ST_DIVIDE: begin
                    if (MINOR_TICK) begin
                        prem <= next_step;
                        quo <= {quo[WW-2:0], ~next_step[MW+1]};
                        digits <= digits + 6'h01;
                        if (digits + 6'h01 == need) begin
                            state <= ST_FIN_Q;
                        end
                    end
                end
                ST_FIN_Q: begin
                    state <= ST_FIN_R;
                end
                ST_FIN_R: begin
                    state <= ST_WAIT3;
                end
                ST_WAIT3: begin
                    if (take) begin
                        quo_addr <= EXEC_ADDR;
                        wr_pend <= 1'b1;
                        wr_addr_pend <= EXEC_ADDR;
                        if (mode == `SDIV_MODE_EXACT) begin
                            state <= ST_WAIT4;
                        end else begin
                            state <= ST_LAST;
                        end
                    end
                end
                ST_WAIT4: begin
                    if (take) begin
                        wr_pend <= 1'b1;
                        wr_addr_pend <= quo_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
                        state <= ST_LAST;
                    end
                end
                ST_LAST: begin
                    if (take) begin
                        ORDER_DATA <= MEM_RD_DATA;
                        ORDER_VALID <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Memory write strobe lines up with the tank's registered read data
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            MEM_WR <= 1'b0;
            MEM_WR_ADDR <= {ADDR_W{1'b0}};
        end else begin
            MEM_WR <= wr_pend;
            if (wr_pend) begin
                MEM_WR_ADDR <= wr_addr_pend;
            end
        end
    end

endmodule // sdiv_unit

/* File: test/sdiv_monitor.sv */
// Port checker for the serial divide unit
`timescale 1ns/10ps
module sdiv_monitor #(
    parameter ADDR_W = 10
) (
    input wire CLK,
    input wire RST,
    input wire MINOR_TICK,
    input wire EXEC,
    input wire MODE_EXACT,
    input wire [ADDR_W-1:0] EXEC_ADDR,
    input wire [43:0] MEM_RD_DATA,
    input wire MEM_WR,
    input wire [ADDR_W-1:0] MEM_WR_ADDR,
    input wire [43:0] MEM_WR_DATA,
    input wire OVERFLOW,
    input wire ORDER_VALID,
    input wire [43:0] ORDER_DATA,
    input wire READY_RESULT,
    input wire BUSY
);
    wire take = EXEC && MINOR_TICK;
    reg [1:0] nex;
    reg [5:0] tcnt;
    reg ovf;
    reg res;
    // Tracks execute count, ticks since divisor load and result phase
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            nex <= 2'h0;
            tcnt <= 6'h00;
            ovf <= 1'b0;
            res <= 1'b0;
        end else begin
            if (take)
                nex <= BUSY ? 2'h2 : 2'h1;
            if (take && BUSY && nex == 2'h1)
                tcnt <= 6'h00;
            else if (MINOR_TICK && !READY_RESULT && tcnt != 6'h3F)
                tcnt <= tcnt + 6'h01;
            if (OVERFLOW)
                ovf <= 1'b1;
            else if (take && !BUSY)
                ovf <= 1'b0;
            if (READY_RESULT)
                res <= 1'b1;
            else if (take && !BUSY)
                res <= 1'b0;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    a_first_copy: assert property (take && !BUSY |-> ##2 MEM_WR &&
        MEM_WR_DATA == $past(MEM_RD_DATA, 2) &&
        MEM_WR_ADDR == $past(EXEC_ADDR, 2))
        else $error("first execute did not copy the dividend");
    a_result_write: assert property (take && READY_RESULT |->
        ##2 MEM_WR && MEM_WR_ADDR == $past(EXEC_ADDR, 2))
        else $error("result write missing");
    a_early_refused: assert property (
        take && BUSY && nex == 2'h2 && !READY_RESULT && !res |-> ##2 !MEM_WR)
        else $error("early result execute was taken");
    a_ovf_ones: assert property (ovf && MEM_WR |->
        MEM_WR_DATA[42:0] == {43{1'b1}})
        else $error("overflow word not all ones");
    a_zero_plus: assert property (
        res && !ovf && MEM_WR && MEM_WR_DATA[42:0] == 43'h0
        |-> !MEM_WR_DATA[43])
        else $error("zero result carries minus sign");
    a_order_word: assert property (ORDER_VALID |->
        $past(take) && ORDER_DATA == $past(MEM_RD_DATA))
        else $error("next order word wrong");
    a_digit_count: assert property (
        $rose(READY_RESULT) && !ovf
        |-> tcnt == (MODE_EXACT ? 6'h2A : 6'h2B))
        else $error("digit cycle count wrong");
    a_ovf_ready: assert property (OVERFLOW |-> ##2 READY_RESULT)
        else $error("overflow did not end digit generation");
    c_overflow: cover property (OVERFLOW);
    c_exact_rem: cover property (res && MEM_WR && MODE_EXACT);
    c_order: cover property (ORDER_VALID);
endmodule // sdiv_monitor

bind sdiv_unit sdiv_monitor #(.ADDR_W(ADDR_W)) i_sdiv_monitor (.*);

/* File: test/sdiv_timing_model.sv */
// Minor-cycle timing model of the memory and dispatcher side
`timescale 1ns/10ps
module sdiv_timing_model #(
    parameter PERIOD = 4
) (
    input wire clk,
    input wire rst,
    output wire minor_tick,
    output wire pre_tick
);
    reg [3:0] phase;
    // Minor boundaries come from the recirculating memory
    always @(posedge clk or posedge rst) begin
        if (rst)
            phase <= 4'h0;
        else
            phase <= (phase == PERIOD - 1) ? 4'h0 : phase + 4'h1;
    end
    assign minor_tick = (phase == PERIOD - 1);
    assign pre_tick = (phase == PERIOD - 2);
endmodule // sdiv_timing_model

/* File: test/tb.sv */
// Self-checking bench for the serial divide unit
`timescale 1ns/10ps
module tb;
    reg CLK;
    reg RST;
    reg EXEC;
    reg MODE_EXACT;
    reg [9:0] EXEC_ADDR;
    reg [43:0] MEM_RD_DATA;
    wire MINOR_TICK, pre_tick, MEM_WR, OVERFLOW, ORDER_VALID;
    wire READY_RESULT, BUSY;
    wire [9:0] MEM_WR_ADDR;
    wire [43:0] MEM_WR_DATA, ORDER_DATA;
    logic [55:0] expq[$];
    int fail_count = 0;
    int total_checks = 0;
    sdiv_unit i_sdiv_unit (.*);
    sdiv_timing_model i_sdiv_timing_model (.clk(CLK), .rst(RST),
        .minor_tick(MINOR_TICK), .pre_tick(pre_tick));
    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end
    task automatic chk(input logic [55:0] g);
        logic [55:0] e;
        e = (expq.size() != 0) ? expq.pop_front() : ~g;
        total_checks++;
        if (e !== g) begin
            fail_count++;
            $display("BAD result exp %h got %h", e, g);
        end
    endtask
    task stop_test;
        if (expq.size() != 0) begin
            fail_count++;
            $display("BAD pending exp 0 got %0d", expq.size());
        end
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic ex(input logic [9:0] a, input logic [43:0] d);
        @(negedge CLK);
        while (!pre_tick) @(negedge CLK);
        @(posedge CLK);
        EXEC <= 1'b1;
        EXEC_ADDR <= a;
        MEM_RD_DATA <= d;
        @(posedge CLK);
        EXEC <= 1'b0;
        MEM_RD_DATA <= ~d;
    endtask
    task automatic div(input logic m, input logic [43:0] a,
                       input logic [43:0] b, input logic [9:0] qa);
        logic [86:0] q;
        logic [42:0] r;
        logic [43:0] qw;
        logic [43:0] rw;
        logic ov;
        int w;
        ov = a[42:0] >= b[42:0];
        q = ov ? 87'h0 : ({a[42:0], 44'h0} >> (m ? 1 : 0)) / b[42:0];
        r = 43'(({a[42:0], 44'h0} >> 1) - q * b[42:0]);
        if (!m)
            q = (q + 87'h1) >> 1;
        qw = {(a[43] ^ b[43]) && (ov || q != 0), ov ? {43{1'b1}} : q[42:0]};
        rw = ov ? {a[43], {43{1'b1}}} : {a[43] && r != 0, r};
        @(posedge CLK);
        MODE_EXACT <= m;
        expq.push_back({2'h1, ~qa, a});
        ex(~qa, a);
        if (ov)
            expq.push_back({2'h3, 54'h0});
        ex(qa ^ 10'h155, b);
        if (!ov)
            ex(qa, rw);
        w = 0;
        while (!READY_RESULT && w < 400) begin
            @(negedge CLK);
            w++;
        end
        expq.push_back({2'h1, qa, qw});
        ex(qa, ~qw);
        if (m) begin
            expq.push_back({2'h1, qa + 10'h001, rw});
            ex(qa + 10'h001, ~rw);
        end
        expq.push_back({2'h2, 10'h000, a ^ b});
        ex(qa, a ^ b);
        repeat (4) @(posedge CLK);
    endtask
    initial begin
        forever begin
            @(negedge CLK);
            if (MEM_WR)
                chk({2'h1, MEM_WR_ADDR, MEM_WR_DATA});
            if (ORDER_VALID)
                chk({2'h2, 10'h000, ORDER_DATA});
            if (OVERFLOW)
                chk({2'h3, 54'h0});
        end
    end
    initial begin
        repeat (20000) @(posedge CLK);
        fail_count++;
        stop_test;
    end
    initial begin
        logic [43:0] a;
        logic [43:0] b;
        RST = 1'b1;
        EXEC = 1'b0;
        MODE_EXACT = 1'b0;
        EXEC_ADDR = 10'h000;
        MEM_RD_DATA = 44'h0;
        void'($urandom(32'h95a4_4fb6));
        repeat (6) @(posedge CLK);
        RST <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            a = 44'({$urandom, $urandom});
            b = 44'({$urandom, $urandom});
            if (a[42:0] > b[42:0])
                {a[42:0], b[42:0]} = {b[42:0], a[42:0]};
            div(i[0], a, b, 10'($urandom));
        end
        div(1'b1, {1'b1, 43'h0}, {1'b0, 43'h123_4567}, 10'h3FF);
        div(1'b0, {1'b1, 43'h0}, {1'b1, 43'h1}, 10'h010);
        div(1'b0, {1'b0, 43'h7FF_FFFF_FFFE}, {1'b1, 43'h7FF_FFFF_FFFF},
            10'h020);
        div(1'b0, {1'b0, 43'h5}, {1'b1, 43'h0}, 10'h030);
        div(1'b1, {1'b1, 43'h0}, {1'b0, 43'h0}, 10'h3FF);
        div(1'b1, {1'b1, 43'h9}, {1'b1, 43'h9}, 10'h040);
        stop_test;
    end
endmodule // tb
